// >>> rtl/csp_pkg.sv
package csp_pkg;
    // Timing base
    localparam int CLK_MHZ     = 40;
    localparam int CLK_HZ      = CLK_MHZ * 1000000;
    localparam int LF_HZ       = 128000;
    localparam int LF_DIV      = CLK_HZ / LF_HZ;
    localparam int CK_RESET    = 14;
    localparam int CK_WAKE     = 6;
    localparam int PCE_CYC     = 4;
    localparam int T_4MS_US    = 4000;
    localparam int T_4P1MS_US  = 4100;
    localparam int T_64MS_US   = 64000;
    localparam int T_65MS_US   = 65000;
    localparam int T_4MS_CYC   = T_4MS_US * CLK_MHZ;
    localparam int T_4P1MS_CYC = T_4P1MS_US * CLK_MHZ;
    localparam int T_64MS_CYC  = T_64MS_US * CLK_MHZ;
    localparam int T_65MS_CYC  = T_65MS_US * CLK_MHZ;
    localparam int MS_W        = 22;
    // Source and start-up time codes
    localparam logic [3:0] SRC_EXT   = 4'h0;
    localparam logic [3:0] SRC_CALRC = 4'h2;
    localparam logic [3:0] SRC_LF    = 4'h3;
    localparam logic [1:0] SUT_SHORT = 2'h0;
    localparam logic [1:0] SUT_MID   = 2'h1;
    localparam logic [1:0] SUT_LONG  = 2'h2;
    // Prescale field
    localparam logic [3:0] DIV_RST_PLAIN = 4'h0;
    localparam logic [3:0] DIV_RST_DIV8  = 4'h3;
    localparam logic [3:0] DIV_MAX       = 4'h8;
    localparam int         PCE_BIT       = 7;
    localparam int         EXTSEL_BIT    = 6;
    // Register map: indices, byte address is four times the index
    localparam logic [11:0] IDX_PRESCALE = 12'h0061;
    localparam logic [11:0] IDX_ASYNC    = 12'h0062;
    localparam logic [11:0] IDX_STATUS   = 12'h0063;
    localparam logic [11:0] ADR_PRESCALE = 12'(IDX_PRESCALE << 2);
    localparam logic [11:0] ADR_ASYNC    = 12'(IDX_ASYNC << 2);
    localparam logic [11:0] ADR_STATUS   = 12'(IDX_STATUS << 2);

    typedef struct packed {
        logic [3:0] clock_source_select_fuses;
        logic [1:0] startup_time_fuses;
        logic       reset_pin_disable_fuse;
        logic       clock_output_fuse;
        logic       divide_by_eight_fuse;
    } csp_fuses_t;

    typedef struct packed {
        logic cpu;
        logic io;
        logic adc;
        logic flash;
    } csp_clk_en_t;

    typedef enum logic [4:0] {
        ST_LATCH = 5'h01,
        ST_DELAY = 5'h02,
        ST_RUN   = 5'h04,
        ST_SLEEP = 5'h08,
        ST_WAKE  = 5'h10
    } csp_state_t;
endpackage

// >>> rtl/csp_tick_gen.sv
`timescale 1ns/1ps
module csp_tick_gen #(
    parameter int DIV = 312
) (
    input  wire logic mclk,
    input  wire logic rst_n,
    output logic      tick
);
    localparam int W = $clog2(DIV);

    logic [W-1:0] cnt_r;

    generate
        if (DIV < 2) begin : g_bad
            $error("csp_tick_gen: DIV must be at least 2");
        end
    endgenerate

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else if (cnt_r == W'(DIV - 1)) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + W'(1);
        end
    end

    assign tick = (cnt_r == W'(DIV - 1));

    property p_tick_gap;
        @(posedge mclk) disable iff (!rst_n)
        tick |=> !tick [*8];
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("low rate tick repeats too soon");
endmodule // csp_tick_gen

// >>> rtl/csp_prescaler.sv
`timescale 1ns/1ps
module csp_prescaler (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       src_tick,
    input  wire logic [3:0] div_sel,
    output logic            tick
);
    logic [7:0] cnt_r;
    logic [3:0] div_act_r;
    logic [7:0] term;

    // New factor taken only at the end of a full old period: no short pulse
    assign term = 8'((9'h001 << div_act_r) - 9'h001);
    assign tick = src_tick && (cnt_r == term);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r     <= '0;
            div_act_r <= 4'h0;
        end else if (tick) begin
            cnt_r     <= '0;
            div_act_r <= div_sel;
        end else if (src_tick) begin
            cnt_r     <= cnt_r + 8'h01;
        end
    end

    property p_switch_at_edge;
        @(posedge mclk) disable iff (!rst_n)
        !tick && src_tick |=> $stable(div_act_r);
    endproperty
    a_switch_at_edge: assert property (p_switch_at_edge) else $error("factor changed mid period");

    property p_load_new;
        @(posedge mclk) disable iff (!rst_n)
        tick |=> (div_act_r == $past(div_sel)) && (cnt_r == 8'h00);
    endproperty
    a_load_new: assert property (p_load_new) else $error("new factor not taken at period end");
endmodule // csp_prescaler

// >>> rtl/csp_clock_ctrl.sv
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
module csp_clock_ctrl #(
    parameter int DLY_4MS   = csp_pkg::T_4MS_CYC,
    parameter int DLY_4P1MS = csp_pkg::T_4P1MS_CYC,
    parameter int DLY_64MS  = csp_pkg::T_64MS_CYC,
    parameter int DLY_65MS  = csp_pkg::T_65MS_CYC
) (
    input  wire logic                mclk,
    input  wire logic                rst_n,
    input  wire csp_pkg::csp_fuses_t fuses,
    input  wire logic                crystal_input_pin,
    input  wire logic                timer_osc_input_pin,
    input  wire logic                sleep_req,
    input  wire logic                wake_req,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic [31:0]              prdata,
    output logic                     pready,
    output logic                     pslverr,
    output csp_pkg::csp_clk_en_t     domain_clk_en,
    output logic                     clock_output_pin_out,
    output logic                     clock_output_pin_oe,
    output logic                     timer_osc_enable,
    output logic                     timer_ext_tick
);
    localparam int MW = csp_pkg::MS_W;

    generate
        if (DLY_4MS < 1 || DLY_4P1MS < 1 || DLY_64MS < 1 || DLY_65MS < 1 ||
            DLY_65MS >= (1 << MW) || DLY_64MS >= (1 << MW)) begin : g_bad
            $error("csp_clock_ctrl: delay parameters out of range");
        end
    endgenerate

    csp_pkg::csp_state_t  state_r;
    csp_pkg::csp_fuses_t  fuse_r;
    logic [4:0]           ck_cnt_r;
    logic [MW-1:0]        ms_cnt_r;
    logic [MW-1:0]        ms_load;
    logic [3:0]           div_r;
    logic [2:0]           pce_cnt_r;
    logic                 pce_act;
    logic                 ext_sel_r;
    logic                 xtal_d_r;
    logic                 tosc_d_r;
    logic                 lf_tick;
    logic                 src_tick;
    logic                 sys_tick;
    logic                 run;
    logic                 setup;
    logic                 hit;
    logic                 wr_acc;
    logic                 wr_pre;
    logic [31:0]          rd_mux;

    // Low rate source from the main clock; 128 kHz does not divide 40 MHz exactly
    csp_tick_gen #(
        .DIV (csp_pkg::LF_DIV)
    ) u_lf (
        .mclk  (mclk),
        .rst_n (rst_n),
        .tick  (lf_tick)
    );

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            xtal_d_r <= 1'b0;
            tosc_d_r <= 1'b0;
        end else begin
            xtal_d_r <= crystal_input_pin;
            tosc_d_r <= timer_osc_input_pin;
        end
    end

    // Source select; other codes run straight from the main clock
    always_comb begin
        if (fuse_r.clock_source_select_fuses == csp_pkg::SRC_LF) begin
            src_tick = lf_tick;
        end else if (fuse_r.clock_source_select_fuses == csp_pkg::SRC_EXT) begin
            src_tick = crystal_input_pin && !xtal_d_r;
        end else begin
            src_tick = 1'b1;
        end
    end

    csp_prescaler u_pre (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .src_tick (src_tick),
        .div_sel  (div_r),
        .tick     (sys_tick)
    );

    // Reset delay length by source and start-up fuses
    always_comb begin
        ms_load = '0;
        unique case (fuses.startup_time_fuses)
            csp_pkg::SUT_SHORT: begin
                if (fuses.reset_pin_disable_fuse) begin
                    ms_load = MW'(DLY_4P1MS);
                end
            end
            csp_pkg::SUT_MID: begin
                ms_load = (fuses.clock_source_select_fuses == csp_pkg::SRC_LF) ?
                          MW'(DLY_4MS) : MW'(DLY_4P1MS);
            end
            csp_pkg::SUT_LONG: begin
                ms_load = (fuses.clock_source_select_fuses == csp_pkg::SRC_LF) ?
                          MW'(DLY_64MS) : MW'(DLY_65MS);
            end
            default: begin
                // Reserved code: take the longest, safest wait
                ms_load = MW'(DLY_65MS);
            end
        endcase
    end

    // Start-up and wake sequencing
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_r  <= csp_pkg::ST_LATCH;
            fuse_r   <= '0;
            ck_cnt_r <= 5'h00;
            ms_cnt_r <= '0;
        end else begin
            unique case (state_r)
                csp_pkg::ST_LATCH: begin
                    fuse_r   <= fuses;
                    ck_cnt_r <= 5'(csp_pkg::CK_RESET);
                    ms_cnt_r <= ms_load;
                    state_r  <= csp_pkg::ST_DELAY;
                end
                csp_pkg::ST_DELAY: begin
                    if (ck_cnt_r != 5'h00) begin
                        if (src_tick) begin
                            ck_cnt_r <= ck_cnt_r - 5'h01;
                        end
                    end else if (ms_cnt_r != '0) begin
                        ms_cnt_r <= ms_cnt_r - MW'(1);
                    end else begin
                        state_r <= csp_pkg::ST_RUN;
                    end
                end
                csp_pkg::ST_RUN: begin
                    if (sleep_req) begin
                        state_r <= csp_pkg::ST_SLEEP;
                    end
                end
                csp_pkg::ST_SLEEP: begin
                    if (wake_req) begin
                        ck_cnt_r <= 5'(csp_pkg::CK_WAKE);
                        state_r  <= csp_pkg::ST_WAKE;
                    end
                end
                csp_pkg::ST_WAKE: begin
                    if (ck_cnt_r == 5'h00) begin
                        state_r <= csp_pkg::ST_RUN;
                    end else if (src_tick) begin
                        ck_cnt_r <= ck_cnt_r - 5'h01;
                    end
                end
            endcase
        end
    end

    assign run = (state_r == csp_pkg::ST_RUN);

    // APB: one registered answer cycle, so every access has zero wait states
    assign setup  = psel && !penable;
    assign hit    = (paddr == csp_pkg::ADR_PRESCALE) || (paddr == csp_pkg::ADR_ASYNC) ||
                    (paddr == csp_pkg::ADR_STATUS);
    assign wr_acc = psel && penable && pready && pwrite && !pslverr;
    assign wr_pre = wr_acc && (paddr == csp_pkg::ADR_PRESCALE);
    assign pce_act = (pce_cnt_r != 3'h0);

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (paddr == csp_pkg::ADR_PRESCALE) begin
            rd_mux[csp_pkg::PCE_BIT] = pce_act;
            rd_mux[3:0]              = div_r;
        end else if (paddr == csp_pkg::ADR_ASYNC) begin
            rd_mux[csp_pkg::EXTSEL_BIT] = ext_sel_r;
        end else if (paddr == csp_pkg::ADR_STATUS) begin
            rd_mux[4:0]  = state_r;
            rd_mux[5]    = timer_osc_enable;
            rd_mux[16:8] = fuse_r;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup && !hit;
            if (setup && !pwrite) begin
                prdata <= rd_mux;
            end
        end
    end

    // Timed change sequence
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pce_cnt_r <= 3'h0;
            div_r     <= csp_pkg::DIV_RST_PLAIN;
        end else if (state_r == csp_pkg::ST_LATCH) begin
            div_r <= fuses.divide_by_eight_fuse ? csp_pkg::DIV_RST_DIV8 : csp_pkg::DIV_RST_PLAIN;
        end else if (wr_pre && pwdata[csp_pkg::PCE_BIT]) begin
            // Only a clean enable opens the window; a rewrite neither extends nor closes it
            if (pwdata[6:0] == 7'h00 && !pce_act) begin
                pce_cnt_r <= 3'(csp_pkg::PCE_CYC);
            end else if (pce_act) begin
                pce_cnt_r <= pce_cnt_r - 3'h1;
            end
        end else if (wr_pre && pce_act) begin
            pce_cnt_r <= 3'h0;
            if (pwdata[3:0] <= csp_pkg::DIV_MAX) begin
                div_r <= pwdata[3:0];
            end
        end else if (pce_act) begin
            pce_cnt_r <= pce_cnt_r - 3'h1;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ext_sel_r <= 1'b0;
        end else if (wr_acc && paddr == csp_pkg::ADR_ASYNC) begin
            ext_sel_r <= pwdata[csp_pkg::EXTSEL_BIT];
        end
    end

    // Registered outputs
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            domain_clk_en        <= '0;
            clock_output_pin_out <= 1'b0;
            clock_output_pin_oe  <= 1'b0;
            timer_osc_enable     <= 1'b0;
            timer_ext_tick       <= 1'b0;
        end else begin
            domain_clk_en        <= {4{sys_tick && run}};
            // Clock-out keeps running through the start-up delay
            clock_output_pin_oe  <= fuse_r.clock_output_fuse;
            clock_output_pin_out <= fuse_r.clock_output_fuse && sys_tick;
            timer_osc_enable     <= run && (fuse_r.clock_source_select_fuses == csp_pkg::SRC_CALRC);
            timer_ext_tick       <= timer_osc_enable && ext_sel_r &&
                                    timer_osc_input_pin && !tosc_d_r;
        end
    end

    property p_gate_off;
        @(posedge mclk) disable iff (!rst_n)
        !run |=> (domain_clk_en == '0);
    endproperty
    a_gate_off: assert property (p_gate_off) else $error("domain clock while not running");

    property p_delay_load;
        @(posedge mclk) disable iff (!rst_n)
        (state_r == csp_pkg::ST_LATCH) && fuses.reset_pin_disable_fuse &&
        (fuses.startup_time_fuses == csp_pkg::SUT_SHORT) |=> (ms_cnt_r == MW'(DLY_4P1MS)) && (ck_cnt_r == 5'd14);
    endproperty
    a_delay_load: assert property (p_delay_load) else $error("short delay not stretched");

    property p_wake_six;
        @(posedge mclk) disable iff (!rst_n)
        (state_r == csp_pkg::ST_SLEEP) && wake_req |=> (state_r == csp_pkg::ST_WAKE) && (ck_cnt_r == 5'd6);
    endproperty
    a_wake_six: assert property (p_wake_six) else $error("wake count not six");

    property p_ext_src;
        @(posedge mclk) disable iff (!rst_n)
        (fuse_r.clock_source_select_fuses == csp_pkg::SRC_EXT) && !crystal_input_pin |-> !src_tick;
    endproperty
    a_ext_src: assert property (p_ext_src) else $error("external source tick without pin edge");

    property p_clkout;
        @(posedge mclk) disable iff (!rst_n)
        sys_tick ##1 fuse_r.clock_output_fuse |-> clock_output_pin_out && clock_output_pin_oe;
    endproperty
    a_clkout: assert property (p_clkout) else $error("divided clock missing on output pin");

    property p_pce_window;
        @(posedge mclk) disable iff (!rst_n)
        pce_act [*4] |=> !pce_act;
    endproperty
    a_pce_window: assert property (p_pce_window) else $error("change window longer than four cycles");

    property p_div_accept;
        @(posedge mclk) disable iff (!rst_n)
        wr_pre && pce_act && !pwdata[csp_pkg::PCE_BIT] && (pwdata[3:0] <= csp_pkg::DIV_MAX)
        |=> (div_r == $past(pwdata[3:0])) && !pce_act;
    endproperty
    a_div_accept: assert property (p_div_accept) else $error("division write in window lost");

    property p_div_refuse;
        @(posedge mclk) disable iff (!rst_n)
        (state_r != csp_pkg::ST_LATCH) && !(wr_pre && pce_act) |=> $stable(div_r);
    endproperty
    a_div_refuse: assert property (p_div_refuse) else $error("division changed outside window");

    property p_div_reset;
        @(posedge mclk) disable iff (!rst_n)
        (state_r == csp_pkg::ST_LATCH) |=> (div_r == ($past(fuses.divide_by_eight_fuse) ? 4'h3 : 4'h0));
    endproperty
    a_div_reset: assert property (p_div_reset) else $error("division reset value wrong");

    property p_timer_rc;
        @(posedge mclk) disable iff (!rst_n)
        timer_ext_tick |-> $past(fuse_r.clock_source_select_fuses) == csp_pkg::SRC_CALRC;
    endproperty
    a_timer_rc: assert property (p_timer_rc) else $error("timer clock without calibrated RC source");
endmodule // csp_clock_ctrl

// >>> bench/csp_ext_src.sv
`timescale 1ns/1ps
module csp_ext_src #(
    parameter int HALF = 2
) (
    input  wire logic mclk,
    input  wire logic rst_n,
    output logic      crystal_input_pin
);
    int cnt_r;

    // Fixed period; it only stops or restarts while the device sits in reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r             <= 0;
            crystal_input_pin <= 1'b0;
        end else if (cnt_r == HALF - 1) begin
            cnt_r             <= 0;
            crystal_input_pin <= ~crystal_input_pin;
        end else begin
            cnt_r <= cnt_r + 1;
        end
    end
endmodule // csp_ext_src

// >>> bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    localparam int SP = 4;
    localparam logic [11:0] PR = csp_pkg::ADR_PRESCALE;
    localparam logic [11:0] ST = csp_pkg::ADR_STATUS;
    logic                 mclk;
    logic                 rst_n;
    csp_pkg::csp_fuses_t  fuses;
    logic                 crystal_input_pin;
    logic                 timer_osc_input_pin;
    logic                 sleep_req;
    logic                 wake_req;
    logic                 psel;
    logic                 penable;
    logic                 pwrite;
    logic [11:0]          paddr;
    logic [31:0]          pwdata;
    logic [31:0]          prdata;
    logic                 pready;
    logic                 pslverr;
    csp_pkg::csp_clk_en_t domain_clk_en;
    logic                 clock_output_pin_out;
    logic                 clock_output_pin_oe;
    logic                 timer_osc_enable;
    logic                 timer_ext_tick;
    int                   fail_count;
    int                   compares;
    logic [31:0]          q;
    logic                 e;
    int                   t0;
    int                   t1;
    int                   p1;
    int                   p2;
    int                   n;
    logic [1:0]           sutv [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
    logic                 rdv  [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
    int                   dv   [4] = '{21, 41, 21, 41};

    csp_clock_ctrl #(.DLY_4MS(20), .DLY_4P1MS(21), .DLY_64MS(40), .DLY_65MS(41)) i_dut (
        .mclk, .rst_n, .fuses, .crystal_input_pin, .timer_osc_input_pin, .sleep_req, .wake_req,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .domain_clk_en,
        .clock_output_pin_out, .clock_output_pin_oe, .timer_osc_enable, .timer_ext_tick);

    csp_ext_src #(.HALF(SP / 2)) i_src (.mclk, .rst_n, .crystal_input_pin);

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic conclude;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rng(input int v, input int lo, input int hi);
        compares++;
        if (v < lo || v > hi) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, v, lo);
        end
    endtask

    // Back-to-back keeps psel up so the next setup follows without a gap
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input bit bb);
        int k;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        q = prdata;
        e = pslverr;
        if (k >= 50) chk(32'h0, 32'h1);
        if (!bb) begin
            psel    <= 1'b0;
            penable <= 1'b0;
            @(posedge mclk);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input bit bb = 1'b0);
        xfer(1'b1, a, d, bb);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000, 1'b0);
        chk(q, exp);
    endtask

    // Cycles until the next pulse on a domain enable or the clock-out pin
    task automatic per(input bit pin, output int p);
        p = 0;
        do begin
            @(posedge mclk);
            p++;
        end while ((pin ? clock_output_pin_out : domain_clk_en.cpu) !== 1'b1 && p < 5000);
        if (!pin) chk({28'h0, domain_clk_en}, 32'h0000_000F);
    endtask

    task automatic boot(input csp_pkg::csp_fuses_t f, input int tmin, output int t);
        int np;
        rst_n <= 1'b0;
        fuses <= f;
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        t = 0;
        np = 0;
        do begin
            @(posedge mclk);
            t++;
            np += int'(clock_output_pin_out === 1'b1);
        end while (domain_clk_en.cpu !== 1'b1 && t < 20000);
        chk({31'h0, clock_output_pin_oe}, {31'h0, f.clock_output_fuse});
        chk({31'h0, np > 0}, {31'h0, f.clock_output_fuse});
        rng(t, tmin, 19999);
    endtask

    task automatic tog(output int c);
        c = 0;
        repeat (3) begin
            timer_osc_input_pin <= 1'b1;
            repeat (4) begin
                @(posedge mclk);
                c += int'(timer_ext_tick === 1'b1);
            end
            timer_osc_input_pin <= 1'b0;
            repeat (4) begin
                @(posedge mclk);
                c += int'(timer_ext_tick === 1'b1);
            end
        end
    endtask

    initial begin
        repeat (60000) @(posedge mclk);
        fail_count++;
        conclude;
    end

    initial begin
        fail_count = 0;
        compares = 0;
        rst_n = 1'b0;
        fuses = '0;
        timer_osc_input_pin = 1'b0;
        sleep_req = 1'b0;
        wake_req = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        @(posedge mclk);
        boot({4'h0, 2'h0, 1'b0, 1'b1, 1'b1}, 14 * SP, t0);
        rd(PR, 32'h0000_0003);
        rd(ST, {15'h0, fuses, 3'h0, 5'h04});
        per(1'b0, p1);
        per(1'b0, p2);
        rng(p2, 8 * SP, 8 * SP);
        boot({4'h0, 2'h0, 1'b0, 1'b0, 1'b0}, 14 * SP, t0);
        rd(PR, 32'h0000_0000);
        for (n = 0; n < 4; n++) begin
            boot({4'h0, sutv[n], rdv[n], 1'b1, 1'b0}, 14 * SP, t1);
            rng(t1 - t0, dv[n] - SP, dv[n] + SP);
        end
        for (n = 0; n <= 8; n++) begin
            wr(PR, 32'h0000_0080, 1'b1);
            wr(PR, 32'(n));
            rd(PR, 32'(n));
            per(1'b0, p1);
            per(1'b0, p1);
            per(1'b0, p2);
            rng(p2, SP << n, SP << n);
            per(1'b1, p1);
            per(1'b1, p2);
            rng(p2, SP << n, SP << n);
        end
        wr(PR, 32'h0000_0080, 1'b1);
        wr(PR, 32'h0000_0000);
        per(1'b0, p1);
        per(1'b0, p1);
        // Slow down by four: the switch must never run faster than the old rate
        wr(PR, 32'h0000_0080, 1'b1);
        wr(PR, 32'h0000_0002);
        per(1'b0, p1);
        per(1'b0, p2);
        rng(p2, SP, 4 * SP);
        rng(p1 + p2, 1, 9 * SP + 4);
        per(1'b0, p2);
        rng(p2, 4 * SP, 4 * SP);
        wr(PR, 32'h0000_0080, 1'b1);
        wr(PR, 32'h0000_0000);
        per(1'b0, p1);
        per(1'b0, p2);
        rng(p1, 1, 4 * SP);
        rng(p2, SP, 4 * SP);
        wr(PR, 32'h0000_0080, 1'b1);
        rd(PR, 32'h0000_0080);
        repeat (6) @(posedge mclk);
        rd(PR, 32'h0000_0000);
        wr(PR, 32'h0000_0005);
        rd(PR, 32'h0000_0000);
        wr(PR, 32'h0000_0080, 1'b1);
        wr(PR, 32'h0000_0081);
        repeat (6) @(posedge mclk);
        rd(PR, 32'h0000_0000);
        wr(PR, 32'h0000_0080, 1'b1);
        wr(PR, 32'h0000_0080);
        wr(PR, 32'h0000_0001);
        rd(PR, 32'h0000_0000);
        wr(PR, 32'h0000_0080, 1'b1);
        wr(PR, 32'h0000_0009);
        rd(PR, 32'h0000_0000);
        rd(12'h000, 32'h0000_0000);
        chk({31'h0, e}, 32'h0000_0001);
        wr(12'h000, 32'hFFFF_FFFF);
        chk({31'h0, e}, 32'h0000_0001);
        sleep_req <= 1'b1;
        @(posedge mclk);
        sleep_req <= 1'b0;
        rd(ST, {15'h0, fuses, 3'h0, 5'h08});
        p1 = 0;
        repeat (40) begin
            @(posedge mclk);
            p1 += int'(domain_clk_en !== 4'h0);
        end
        rng(p1, 0, 0);
        wake_req <= 1'b1;
        per(1'b0, p1);
        wake_req <= 1'b0;
        rng(p1, 5 * SP, 8 * SP);
        boot({4'h2, 2'h0, 1'b0, 1'b0, 1'b0}, 14, t0);
        chk({31'h0, timer_osc_enable}, 32'h0000_0001);
        rd(ST, {15'h0, fuses, 2'h0, 1'b1, 5'h04});
        tog(p1);
        rng(p1, 0, 0);
        wr(csp_pkg::ADR_ASYNC, 32'h0000_0040);
        rd(csp_pkg::ADR_ASYNC, 32'h0000_0040);
        tog(p1);
        rng(p1, 3, 3);
        boot({4'h3, 2'h0, 1'b0, 1'b0, 1'b0}, 14 * csp_pkg::LF_DIV, t0);
        chk({31'h0, timer_osc_enable}, 32'h0000_0000);
        per(1'b0, p1);
        per(1'b0, p2);
        rng(p2, csp_pkg::LF_DIV, csp_pkg::LF_DIV);
        // Low rate, medium start-up: state read one cycle either side of the short count's end
        rst_n <= 1'b0;
        fuses <= {4'h3, 2'h1, 1'b0, 1'b0, 1'b0};
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (14 * csp_pkg::LF_DIV + 19) @(posedge mclk);
        xfer(1'b0, ST, 32'h0000_0000, 1'b1);
        chk(q, {15'h0, fuses, 3'h0, 5'h02});
        rd(ST, {15'h0, fuses, 3'h0, 5'h04});
        conclude;
    end
endmodule // testbench
